/* bench/led_panel_operator.sv */
// Operator model: sets switch, Hall and port pins and counts lit LEDs.
`timescale 1ns/1ps
`default_nettype none
module led_panel_operator (
    // Clock
    input wire logic pclk,
    // Pins the operator sets
    output logic [7:0] node_number_switch,
    output logic [2:0] hall_in,
    output logic [1:0] port_link,
    output logic [1:0] port_activity,
    // Indicators the operator looks at
    input wire logic led_dg,
    input wire logic led_dr,
    input wire logic led_cg,
    input wire logic led_cr,
    input wire logic led_p0
);
    int cnt [6];

    // Pins start quiet with the Hall inputs not grounded.
    initial begin
        node_number_switch = 8'h00;
        hall_in = 3'h7;
        port_link = 2'h0;
        port_activity = 2'h0;
    end

    // A hand on the pins is seen just after a clock edge.
    task automatic set_pins(input logic [7:0] s, input logic [2:0] h,
                            input logic [1:0] l, input logic [1:0] a);
        @(posedge pclk);
        node_number_switch <= s;
        hall_in <= h;
        port_link <= l;
        port_activity <= a;
    endtask : set_pins

    // Counting over whole pattern periods makes the result phase free.
    task automatic watch(input int n);
        int i;
        cnt = '{default: 0};
        for (i = 0; i < n; i++) begin
            @(posedge pclk);
            cnt[0] += int'(led_cg);
            cnt[1] += int'(led_cr);
            cnt[2] += int'(led_dg);
            cnt[3] += int'(led_dr);
            cnt[4] += int'(led_p0);
            cnt[5] += int'(led_cg & led_cr);
        end
    endtask : watch
endmodule : led_panel_operator
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the drive status and node identity block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import drive_status_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, sw, node_number;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] hall;
    logic [1:0] lnk, act, port_led;
    logic [15:0] station_alias;
    logic dg, dr, cg, cr, fault_output;
    int error_cnt;
    int checked;

    drive_status_node_id #(.tick_cycles(4)) u_drive_status_node_id (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .node_number_switch(sw),
        .hall_in(hall), .port_link(lnk), .port_activity(act),
        .node_number(node_number), .station_alias(station_alias),
        .drive_status_led_green(dg), .drive_status_led_red(dr),
        .combined_run_error_led_green(cg), .combined_run_error_led_red(cr),
        .port_led(port_led), .fault_output(fault_output));

    led_panel_operator u_led_panel_operator (
        .pclk(pclk), .node_number_switch(sw), .hall_in(hall),
        .port_link(lnk), .port_activity(act), .led_dg(dg), .led_dr(dr),
        .led_cg(cg), .led_cr(cr), .led_p0(port_led[0]));

    // 50 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // One APB transfer; entered just after an edge, held until pready.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("pready", 32'h1, 32'h0);
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Pins are stable through the whole reset so the captures settle.
    task automatic do_reset(input logic [7:0] s, input logic [2:0] h);
        u_led_panel_operator.set_pins(s, h, 2'h0, 2'h0);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_capture();
        chk("node", 32'h00a5, 32'(node_number));
        u_led_panel_operator.set_pins(8'h3c, 3'h5, 2'h0, 2'h0);
        repeat (5) @(posedge pclk);
        chk("node held", 32'h00a5, 32'(node_number));
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h00a5_02a5, rd);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", CTRL_RESET, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        apb(1'b1, CTRL_OFS, 32'h0000_3707);
        // Node and alias registers follow the control register a cycle on.
        repeat (2) @(posedge pclk);
        chk("hw node", 32'h00a5, 32'(node_number));
        chk("hw alias", 32'h00a5, 32'(station_alias));
    endtask : t_capture

    // Period counts: flicker and blink half lit, single 4 of 24, double 8 of 28.
    task automatic t_patterns();
        int i;
        int red [6] = '{0, 672, 192, 112, 336, 336};
        int grn [4] = '{0, 336, 112, 672};
        for (i = 0; i < 6; i++) begin
            apb(1'b1, BUS_STATE_OFS, {21'h0, 3'(i), 8'h01});
            u_led_panel_operator.watch(672);
            chk("error led", 32'(red[i]), 32'(u_led_panel_operator.cnt[1]));
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, BUS_STATE_OFS, 32'(1 << i));
            u_led_panel_operator.watch(672);
            chk("run led", 32'(grn[i]), 32'(u_led_panel_operator.cnt[0]));
        end
        apb(1'b1, BUS_STATE_OFS, 32'h0000_0502);
        u_led_panel_operator.watch(672);
        chk("shifted run", 32'd336, 32'(u_led_panel_operator.cnt[0]));
        apb(1'b1, BUS_STATE_OFS, 32'h0000_0108);
        u_led_panel_operator.watch(672);
        chk("red wins", 32'd672, 32'(u_led_panel_operator.cnt[1]));
        chk("both lit", 32'd0, 32'(u_led_panel_operator.cnt[5]));
    endtask : t_patterns

    task automatic t_ports();
        u_led_panel_operator.set_pins(8'ha5, 3'h5, 2'h1, 2'h0);
        repeat (4) @(posedge pclk);
        chk("port led", 32'h1, 32'(port_led));
        u_led_panel_operator.set_pins(8'ha5, 3'h5, 2'h2, 2'h0);
        repeat (4) @(posedge pclk);
        chk("port led", 32'h2, 32'(port_led));
        u_led_panel_operator.set_pins(8'ha5, 3'h5, 2'h3, 2'h3);
        // Let the synchronisers settle so only whole periods are counted.
        repeat (4) @(posedge pclk);
        u_led_panel_operator.watch(672);
        chk("traffic", 32'd336, 32'(u_led_panel_operator.cnt[4]));
    endtask : t_ports

    // A software node of zero is the awkward case: it must become one.
    task automatic t_sw_node();
        chk("node other bits", 32'h005a, 32'(node_number));
        apb(1'b1, CTRL_OFS, 32'h0000_0006);
        repeat (2) @(posedge pclk);
        chk("sw node", 32'h0001, 32'(node_number));
        chk("sw alias", 32'h0001, 32'(station_alias));
        chk("drive leds", 32'h2, 32'({dg, dr}));
        apb(1'b1, CTRL_OFS, 32'h0000_0016);
        repeat (2) @(posedge pclk);
        chk("drive leds", 32'h1, 32'({dg, dr}));
        apb(1'b1, CTRL_OFS, 32'h0000_000e);
        // The red LED reads the registered fault output, one more cycle.
        repeat (2) @(posedge pclk);
        chk("fault out", 32'h3, 32'({fault_output, dr}));
        apb(1'b1, CTRL_OFS, 32'h0000_0024);
        u_led_panel_operator.watch(672);
        chk("loop green", 32'd336, 32'(u_led_panel_operator.cnt[2]));
        chk("loop red", 32'd336, 32'(u_led_panel_operator.cnt[3]));
    endtask : t_sw_node

    task automatic t_invalid();
        chk("all off node", 32'h00ff, 32'(node_number));
        chk("all off alias", 32'h0, 32'(station_alias));
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h0000_03ff, rd);
        apb(1'b0, MOTION_FAULT_OFS, 32'h0);
        chk("motion fault", 32'h4, rd);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("defaults", CTRL_RESET, rd);
    endtask : t_invalid

    // Main sequence; every input has a value at time zero.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        checked = 0;
        do_reset(8'ha5, 3'h5);
        t_capture();
        t_patterns();
        t_ports();
        do_reset(8'h5a, 3'h2);
        t_sw_node();
        do_reset(8'h00, 3'h0);
        t_invalid();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire

/* hdl/drive_status_node_id.sv */
// Drive status LEDs, node number capture and APB register slave.
`timescale 1ns/1ps
`default_nettype none
module drive_status_node_id
    import drive_status_pkg::*;
#(
    parameter int unsigned tick_cycles = TICK_CYCLES_DEF
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins sampled at power-up
    input wire logic [7:0] node_number_switch,
    input wire logic [2:0] hall_in,
    // Port link pins
    input wire logic [1:0] port_link,
    input wire logic [1:0] port_activity,
    // Identity results
    output logic [7:0] node_number,
    output logic [15:0] station_alias,
    // Indicators
    output logic drive_status_led_green,
    output logic drive_status_led_red,
    output logic combined_run_error_led_green,
    output logic combined_run_error_led_red,
    output logic [1:0] port_led,
    output logic fault_output
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // No reset here, so the pins are settled by the time reset lifts.
    logic [7:0] sw_meta, sw_sync;
    logic [2:0] hall_meta, hall_sync;
    logic [1:0] link_meta, link_sync, act_meta, act_sync;

    always_ff @(posedge pclk) begin
        sw_meta <= node_number_switch;
        sw_sync <= sw_meta;
        hall_meta <= hall_in;
        hall_sync <= hall_meta;
        link_meta <= port_link;
        link_sync <= link_meta;
        act_meta <= port_activity;
        act_sync <= act_meta;
    end

    // ----------------------------------------------------------------
    // Power-up capture
    // ----------------------------------------------------------------
    logic captured;
    logic [7:0] switch_value;
    logic setup_invalid;

    // The capture happens once; only a new reset can take it again.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured <= 1'b0;
            switch_value <= 8'h0;
            setup_invalid <= 1'b0;
        end else if (!captured) begin
            captured <= 1'b1;
            switch_value <= sw_sync;
            setup_invalid <= (hall_sync == 3'h0);
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [3:0] slave_state;
    logic [2:0] err_code;
    logic [7:0] motion_fault;
    logic sw_applied;
    logic [7:0] applied_sw_node;

    wire setup_phase = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_status = (paddr == STATUS_OFS);
    wire hit_bus = (paddr == BUS_STATE_OFS);
    wire hit_fault = (paddr == MOTION_FAULT_OFS);
    wire mapped = hit_ctrl || hit_status || hit_bus || hit_fault;

    wire hw_source = ctrl[HW_SOURCE_BIT];
    wire alias_mode = ctrl[ALIAS_MODE_BIT];
    wire init_done = ctrl[INIT_DONE_BIT];
    wire drive_error = ctrl[DRIVE_ERROR_BIT];
    wire reset_loop = ctrl[RESET_LOOP_BIT];
    wire [7:0] sw_node_field = pwdata[SW_NODE_LSB +: 8];
    // Zero is outside the legal range and is raised to one.
    wire [7:0] sw_node_legal = (sw_node_field == 8'h0) ? 8'h1 : sw_node_field;
    wire init_rise = wr_en && hit_ctrl && pwdata[INIT_DONE_BIT] && !init_done;

    // An invalid setup forces CTRL_RESET, so software fields return to defaults (node field to one).
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            slave_state <= SLAVE_INIT;
            err_code <= ERR_NONE;
        end else if (wr_en && hit_ctrl) begin
            ctrl <= {pwdata[31:SW_NODE_LSB + 8], sw_node_legal,
                pwdata[SW_NODE_LSB - 1:0]};
        end else if (captured && setup_invalid && !sw_applied) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && hit_bus) begin
            slave_state <= pwdata[3:0];
            err_code <= pwdata[ERR_CODE_LSB +: 3];
        end
    end

    // The software node number is taken once, when init completes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_applied <= 1'b0;
            applied_sw_node <= 8'h1;
        end else if (init_rise && !sw_applied) begin
            sw_applied <= 1'b1;
            applied_sw_node <= sw_node_legal;
        end
    end

    // The fault flag is set by hardware; the set wins over a clear.
    wire fault_set = captured && setup_invalid && !sw_applied;
    wire fault_clr = wr_en && hit_fault && pwdata[INVALID_SETUP_FAULT_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motion_fault <= 8'h0;
        end else if (fault_set) begin
            motion_fault[INVALID_SETUP_FAULT_BIT] <= 1'b1;
        end else if (fault_clr) begin
            motion_fault[INVALID_SETUP_FAULT_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Node number and station alias
    // ----------------------------------------------------------------
    wire all_off = (switch_value == 8'h0);
    wire [7:0] hw_node = all_off ? ALL_OFF_NODE : switch_value;
    wire use_hw = hw_source || setup_invalid || !sw_applied;
    wire [7:0] next_node = use_hw ? hw_node : applied_sw_node;
    wire [15:0] next_alias = (alias_mode && !(use_hw && all_off)) ?
        {8'h0, next_node} : 16'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_number <= ALL_OFF_NODE;
            station_alias <= 16'h0;
        end else if (captured) begin
            node_number <= next_node;
            station_alias <= next_alias;
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // Every transfer ends in its first access cycle.
    wire [31:0] status_word = {8'h0, switch_value, 6'h0, use_hw,
        setup_invalid, node_number};
    wire [31:0] bus_word = {21'h0, err_code, 4'h0, slave_state};
    wire [31:0] read_mux = hit_ctrl ? ctrl :
        hit_status ? status_word :
        hit_bus ? bus_word :
        hit_fault ? {24'h0, motion_fault} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !mapped;
            prdata <= (setup_phase && !pwrite) ? read_mux : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // Pattern source
    // ----------------------------------------------------------------
    logic flicker, blink_r, single_r, double_r;
    logic blink_g, single_g, double_g;

    led_pattern_gen #(
        .tick_cycles(tick_cycles)
    ) u_patterns (
        .pclk(pclk),
        .presetn(presetn),
        .flicker(flicker),
        .blink_r(blink_r),
        .single_r(single_r),
        .double_r(double_r),
        .blink_g(blink_g),
        .single_g(single_g),
        .double_g(double_g)
    );

    // ----------------------------------------------------------------
    // Indicator decode
    // ----------------------------------------------------------------
    logic run_on, err_on;

    // Run side of the bicolour LED.
    always_comb begin
        case (slave_state)
            SLAVE_INIT: run_on = 1'b0;
            SLAVE_PREOP: run_on = blink_g;
            SLAVE_SAFEOP: run_on = single_g;
            SLAVE_OP: run_on = 1'b1;
            default: run_on = 1'b0;
        endcase
    end

    // Error side of the bicolour LED.
    always_comb begin
        case (err_code)
            ERR_CRITICAL: err_on = 1'b1;
            ERR_WATCHDOG: err_on = double_r;
            ERR_LOCAL: err_on = single_r;
            ERR_BOOTING: err_on = flicker;
            ERR_CONFIG: err_on = blink_r;
            default: err_on = 1'b0;
        endcase
    end

    // A reset loop can only be seen as brief flashes on both colours.
    wire next_drv_green = reset_loop ? flicker :
        (init_done && !drive_error && !fault_output);
    wire next_drv_red = reset_loop ? flicker :
        (drive_error || fault_output);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_status_led_green <= 1'b0;
            drive_status_led_red <= 1'b0;
            combined_run_error_led_green <= 1'b0;
            combined_run_error_led_red <= 1'b0;
            fault_output <= 1'b0;
        end else begin
            drive_status_led_green <= next_drv_green;
            drive_status_led_red <= next_drv_red;
            combined_run_error_led_green <= run_on && !err_on;
            combined_run_error_led_red <= err_on;
            fault_output <= ctrl[FAULT_OUT_BIT];
        end
    end

    // Port LEDs: steady on link, blanked by flicker while traffic flows.
    // One register process keeps a single driver on the whole vector.
    wire [1:0] next_port_led;
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            assign next_port_led[p] = link_sync[p] &&
                !(act_sync[p] && flicker);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_led <= 2'h0;
        end else begin
            port_led <= next_port_led;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    a_apb_one_wait: assert property (
        s_setup |=> pready ##1 !pready)
        else $error("APB answer not in first access cycle");
    a_switch_held: assert property (
        captured |=> $stable(switch_value) && $stable(setup_invalid))
        else $error("captured switch value changed");
    a_all_off_node: assert property (
        captured && all_off && use_hw |=> node_number == 8'hff
        && station_alias == 16'h0)
        else $error("all-off switches gave wrong node or alias");
    a_hw_node_used: assert property (
        captured && hw_source && !all_off |=> node_number == switch_value)
        else $error("hardware node number not applied");
    a_alias_follows: assert property (
        captured && alias_mode && !all_off && hw_source
        |=> station_alias[7:0] == switch_value)
        else $error("station alias not loaded with node number");
    a_fault_bit_set: assert property (
        captured && setup_invalid && !sw_applied
        |=> motion_fault[INVALID_SETUP_FAULT_BIT])
        else $error("invalid setup fault bit not set");
    a_red_wins: assert property (
        !(combined_run_error_led_green && combined_run_error_led_red))
        else $error("bicolour LED lit both colours");
    a_red_on_error: assert property (
        !reset_loop && drive_error |=> drive_status_led_red
        && !drive_status_led_green)
        else $error("drive error not shown red");
    a_run_steady_op: assert property (
        slave_state == SLAVE_OP && err_code == ERR_NONE
        |=> combined_run_error_led_green)
        else $error("operational state not steady green");
    a_port_link_down: assert property (
        !link_sync[0] |=> !port_led[0])
        else $error("port LED lit without link");
    a_critical_on: assert property (
        err_code == ERR_CRITICAL ##1 err_code == ERR_CRITICAL
        |-> combined_run_error_led_red)
        else $error("critical error not steady red");

endmodule : drive_status_node_id
`default_nettype wire

/* hdl/led_pattern_gen.sv */
// Time base and indicator pattern generator for the status LEDs.
`timescale 1ns/1ps
`default_nettype none
module led_pattern_gen
    import drive_status_pkg::*;
#(
    parameter int unsigned tick_cycles = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Error-phase patterns
    output logic flicker,
    output logic blink_r,
    output logic single_r,
    output logic double_r,
    // Run-phase patterns, half a period later
    output logic blink_g,
    output logic single_g,
    output logic double_g
);

    logic [31:0] div;
    logic tick;
    logic [2:0] blink_cnt;
    logic [4:0] single_cnt;
    logic [4:0] double_cnt;
    logic [4:0] single_sh;
    logic [4:0] double_sh;

    // ----------------------------------------------------------------
    // Common time base
    // ----------------------------------------------------------------
    // One enable pulse per tick keeps every pattern on the same clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (div == tick_cycles - 1);
            div <= (div == tick_cycles - 1) ? 32'h0 : div + 32'h1;
        end
    end

    // Counters wrap at their pattern period; all advance on one tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flicker <= 1'b0;
            blink_cnt <= 3'h0;
            single_cnt <= 5'h0;
            double_cnt <= 5'h0;
        end else if (tick) begin
            flicker <= ~flicker;
            blink_cnt <= blink_cnt + 3'h1;
            single_cnt <= (single_cnt == SINGLE_PERIOD - 5'h1) ?
                5'h0 : single_cnt + 5'h1;
            double_cnt <= (double_cnt == DOUBLE_PERIOD - 5'h1) ?
                5'h0 : double_cnt + 5'h1;
        end
    end

    // ----------------------------------------------------------------
    // Pattern decode
    // ----------------------------------------------------------------
    // Shifted counters give the single and double run patterns their half-period offset; blink_g is inverted.
    assign single_sh = (single_cnt >= (SINGLE_PERIOD >> 1)) ?
        single_cnt - (SINGLE_PERIOD >> 1) : single_cnt + (SINGLE_PERIOD >> 1);
    assign double_sh = (double_cnt >= (DOUBLE_PERIOD >> 1)) ?
        double_cnt - (DOUBLE_PERIOD >> 1) : double_cnt + (DOUBLE_PERIOD >> 1);
    assign blink_r = blink_cnt[2];
    assign blink_g = ~blink_cnt[2];
    assign single_r = (single_cnt < FLASH_TICKS);
    assign single_g = (single_sh < FLASH_TICKS);
    assign double_r = (double_cnt < FLASH_TICKS) ||
        (double_cnt >= 2 * FLASH_TICKS && double_cnt < DOUBLE_GAP_END);
    assign double_g = (double_sh < FLASH_TICKS) ||
        (double_sh >= 2 * FLASH_TICKS && double_sh < DOUBLE_GAP_END);

endmodule : led_pattern_gen
`default_nettype wire

/* shared/drive_status_pkg.sv */
// Constants shared by the drive status and node identity logic.
package drive_status_pkg;

    // ----------------------------------------------------------------
    // Clock and indicator timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_MS = 50; // Flicker half period.
    localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_MS;
    // Pattern lengths counted in ticks.
    localparam logic [4:0] FLASH_TICKS = 5'h04;
    localparam logic [4:0] SINGLE_PERIOD = 5'h18;
    localparam logic [4:0] DOUBLE_PERIOD = 5'h1c;
    localparam logic [4:0] DOUBLE_GAP_END = 5'h0c;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] BUS_STATE_OFS = 8'h08;
    localparam logic [7:0] MOTION_FAULT_OFS = 8'h0c;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int HW_SOURCE_BIT = 0;
    localparam int ALIAS_MODE_BIT = 1;
    localparam int INIT_DONE_BIT = 2;
    localparam int FAULT_OUT_BIT = 3;
    localparam int DRIVE_ERROR_BIT = 4;
    localparam int RESET_LOOP_BIT = 5;
    localparam int SW_NODE_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

    // ----------------------------------------------------------------
    // Status, bus state and fault fields
    // ----------------------------------------------------------------
    localparam int SETUP_INVALID_BIT = 8;
    localparam int NODE_FROM_HW_BIT = 9;
    localparam int SWITCH_LSB = 16;
    localparam int ERR_CODE_LSB = 8;
    localparam int INVALID_SETUP_FAULT_BIT = 2;
    localparam logic [7:0] ALL_OFF_NODE = 8'hff;

    // Slave state, one-hot as software writes it.
    typedef enum logic [3:0] {
        SLAVE_INIT = 4'h1,
        SLAVE_PREOP = 4'h2,
        SLAVE_SAFEOP = 4'h4,
        SLAVE_OP = 4'h8
    } slave_state_t;

    // Error indicator causes.
    typedef enum logic [2:0] {
        ERR_NONE = 3'h0,
        ERR_CRITICAL = 3'h1,
        ERR_WATCHDOG = 3'h2,
        ERR_LOCAL = 3'h3,
        ERR_BOOTING = 3'h4,
        ERR_CONFIG = 3'h5
    } err_code_t;

endpackage : drive_status_pkg
